// ### design/ssps_params.svh
// constants of the sensor source priority selector
`ifndef SSPS_PARAMS_SVH
`define SSPS_PARAMS_SVH

// ******
// ports and ranking
// ******
`define SSPS_NPORTS 6
`define SSPS_PORT_W 3

// ******
// timing
// ******
`define SSPS_CLK_HZ 64'h5f5e100
`define SSPS_SILENCE_S 64'h1e
`define SSPS_TIMER_W 32

// ******
// register map (byte addresses)
// ******
`define SSPS_ADDR_W 12
`define SSPS_OFF_COMPAT 12'h000
`define SSPS_OFF_SERIAL 12'h004
`define SSPS_OFF_SOURCE 12'h008
`define SSPS_OFF_QUAL 12'h00c

// ******
// reset values and serial number fields
// ******
`define SSPS_COMPAT_RST 6'h00
`define SSPS_SERIAL_RST 20'h00000
`define SSPS_SERIAL_W 20
`define SSPS_WEEK_MAX 6'h34
`define SSPS_YEAR_MAX 3'h7
`define SSPS_COUNT_MAX 11'h7ff
`define SSPS_FIX_NONE 4'h0
`define SSPS_FIX_GNSS 4'h1

`endif

// ### design/ssps_pkg.sv
// types shared by the sensor source priority selector
`include "ssps_params.svh"
package ssps_pkg;

    // input ports, in falling rank
    typedef enum logic [`SSPS_PORT_W-1:0] {
        PORT_SENSOR1, PORT_SENSOR2, PORT_SENSOR3, PORT_EXT_DISPLAY, PORT_PILOT, PORT_LONG_RANGE
    } ssps_port_t;

    // sentence kinds reported by the parser
    typedef enum logic [4:0] {
        SK_DTM, SK_RMC, SK_GGA, SK_GNS, SK_GLL, SK_GBS, SK_GRS, SK_GSA, SK_GSV, SK_GFA,
        SK_VTG, SK_VBW, SK_HDT, SK_THS, SK_ROT, SK_OTHER
    } ssps_kind_t;

    // one parsed sentence
    typedef struct packed {
        logic valid;        // one-cycle strobe
        ssps_port_t port;   // arriving port
        ssps_kind_t kind;   // sentence type
        logic datumOk;      // datum is WGS84 or overridden (datum sentences)
        logic [3:0] fixQ;   // fix quality field (position sentences)
    } ssps_sentence_t;

    // chosen source of one quantity
    typedef struct packed {
        logic avail;        // a qualifying port exists
        ssps_port_t port;   // selected port
    } ssps_sel_t;

    // sources of all four quantities
    typedef struct packed {
        ssps_sel_t pos;
        ssps_sel_t cog;
        ssps_sel_t hdg;
        ssps_sel_t rot;
    } ssps_sources_t;

    // static data part B answer
    typedef struct packed {
        logic valid;
        logic [`SSPS_SERIAL_W-1:0] serial;
    } ssps_static_t;

endpackage

// ### design/ssps_prio_pick.sv
// fixed-priority picker: lowest index that requests wins
`timescale 1ns/10ps
`default_nettype none
`include "ssps_params.svh"
module ssps_prio_pick (
    input wire logic [`SSPS_NPORTS-1:0] req,
    output logic found,
    output ssps_pkg::ssps_port_t port
);
    import ssps_pkg::*;

    // ******
    // priority search
    // ******
    // scan from lowest rank upward so the highest rank is written last
    always_comb begin
        found = 1'b0;
        port = PORT_SENSOR1;
        for (int i = `SSPS_NPORTS - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                port = ssps_port_t'(i[`SSPS_PORT_W-1:0]);
            end
        end
    end
endmodule
`default_nettype wire

// ### design/ssps_silence_timer.sv
// silence timer: pulses when a running source stays quiet too long
`timescale 1ns/10ps
`default_nettype none
`include "ssps_params.svh"
module ssps_silence_timer #(
    parameter logic [`SSPS_TIMER_W-1:0] LIMIT = `SSPS_TIMER_W'(`SSPS_SILENCE_S * `SSPS_CLK_HZ)
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic restart,
    output logic expire
);
    logic [`SSPS_TIMER_W-1:0] count; // cycles of silence so far
    logic [`SSPS_TIMER_W-1:0] next_count;
    logic next_expire;

    // ******
    // next count
    // ******
    always_comb begin
        next_count = count + `SSPS_TIMER_W'(1);
        next_expire = 1'b0;
        if (!run || restart) begin
            next_count = '0;
        end else if (count == LIMIT - `SSPS_TIMER_W'(1)) begin
            next_count = '0;
            next_expire = 1'b1;
        end
    end

    // ******
    // registers
    // ******
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            count <= '0;
            expire <= 1'b0;
        end else begin
            count <= next_count;
            expire <= next_expire;
        end
    end
endmodule
`default_nettype wire

// ### design/ssps_top.sv
// sensor source priority selector with its apb register slave
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "ssps_params.svh"
// Functional notes
// - six ports ranked, sensor one highest
// - each quantity uses highest qualifying port only
// - position from datum plus RMC port
// - without RMC, datum plus GGA/GNS/GLL
// - position-group sentences only from position source
// - thirty silent seconds drop position source
// - course from VTG, VBW or RMC+datum
// - VTG/VBW only from course source
// - thirty silent seconds drop course source
// - heading from HDT or THS port
// - HDT/THS only from heading source
// - thirty silent seconds drop heading source
// - rate of turn from ROT port only
// - thirty silent seconds drop turn source
// - compatibility mode reduces nonzero fix quality to one
// - compatibility setting held per port
// - serial packs week, year, count fields
// - serial sent on interrogation type fifteen
module ssps_top #(
    parameter logic [`SSPS_TIMER_W-1:0] SILENCE_CYCLES =
        `SSPS_TIMER_W'(`SSPS_SILENCE_S * `SSPS_CLK_HZ)
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`SSPS_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ssps_pkg::ssps_sentence_t sentenceIn,
    input wire logic interrogate15,
    output ssps_pkg::ssps_sentence_t sentenceOut,
    output ssps_pkg::ssps_sources_t sources,
    output ssps_pkg::ssps_static_t staticB
);
    import ssps_pkg::*;

    // ******
    // declarations
    // ******
    logic [`SSPS_NPORTS-1:0] compat; // per-port compatibility mode
    logic [`SSPS_SERIAL_W-1:0] serial; // packed unit serial number
    logic [`SSPS_NPORTS-1:0] qDatum; // port reported a good datum
    logic [`SSPS_NPORTS-1:0] qRmc; // port reported RMC, for position
    logic [`SSPS_NPORTS-1:0] qFix; // port reported GGA, GNS or GLL
    logic [`SSPS_NPORTS-1:0] qCogRmc; // port reported RMC, for course
    logic [`SSPS_NPORTS-1:0] qVel; // port reported VTG or VBW
    logic [`SSPS_NPORTS-1:0] qHdg; // port reported HDT or THS
    logic [`SSPS_NPORTS-1:0] qRot; // port reported ROT
    logic [`SSPS_NPORTS-1:0] next_qDatum;
    logic [`SSPS_NPORTS-1:0] next_qRmc;
    logic [`SSPS_NPORTS-1:0] next_qFix;
    logic [`SSPS_NPORTS-1:0] next_qCogRmc;
    logic [`SSPS_NPORTS-1:0] next_qVel;
    logic [`SSPS_NPORTS-1:0] next_qHdg;
    logic [`SSPS_NPORTS-1:0] next_qRot;
    logic [`SSPS_NPORTS-1:0] portHot; // one-hot arriving port
    logic isPosKind; // sentence belongs to the position group
    logic isPosData; // sentence carries a position
    logic isVelKind; // VTG or VBW
    logic isHdgKind; // HDT or THS
    ssps_sources_t next_sources;
    logic pickRmcFound, pickFixFound, pickCogFound, pickHdgFound, pickRotFound;
    ssps_port_t pickRmcPort, pickFixPort, pickCogPort, pickHdgPort, pickRotPort;
    logic updPos, updCog, updHdg, updRot; // update from the selected port
    logic expPos, expCog, expHdg, expRot; // silence expiry pulses
    ssps_sentence_t next_sentenceOut;
    ssps_static_t next_staticB;
    logic [`SSPS_NPORTS-1:0] next_compat;
    logic [`SSPS_SERIAL_W-1:0] next_serial;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic busAccess; // access phase in its wait cycle, before pready rises
    logic mapped; // address hits a register

    // ******
    // sentence classification
    // ******
    always_comb begin
        portHot = '0;
        portHot[sentenceIn.port] = sentenceIn.valid;
        isPosData = sentenceIn.kind inside {SK_RMC, SK_GGA, SK_GNS, SK_GLL};
        isPosKind = isPosData || (sentenceIn.kind inside {SK_GBS, SK_GRS, SK_GSA, SK_GSV, SK_GFA});
        isVelKind = sentenceIn.kind inside {SK_VTG, SK_VBW};
        isHdgKind = sentenceIn.kind inside {SK_HDT, SK_THS};
    end

    // ******
    // qualification flags
    // ******
    // a timeout clears the dropped port; a report in the same cycle wins
    always_comb begin
        next_qDatum = qDatum;
        next_qRmc = qRmc;
        next_qFix = qFix;
        next_qCogRmc = qCogRmc;
        next_qVel = qVel;
        next_qHdg = qHdg;
        next_qRot = qRot;
        // drop silent sources so the ranking reruns
        if (expPos) begin
            next_qRmc[sources.pos.port] = 1'b0;
            next_qFix[sources.pos.port] = 1'b0;
        end
        if (expCog) begin
            next_qCogRmc[sources.cog.port] = 1'b0;
            next_qVel[sources.cog.port] = 1'b0;
        end
        if (expHdg) begin
            next_qHdg[sources.hdg.port] = 1'b0;
        end
        if (expRot) begin
            next_qRot[sources.rot.port] = 1'b0;
        end
        // reports mark the port as able to supply
        unique case (sentenceIn.kind)
            SK_DTM: begin
                next_qDatum = (qDatum & ~portHot) | (sentenceIn.datumOk ? portHot : '0);
            end
            SK_RMC: begin
                next_qRmc = next_qRmc | portHot;
                next_qCogRmc = next_qCogRmc | portHot;
            end
            SK_GGA, SK_GNS, SK_GLL: begin
                next_qFix = next_qFix | portHot;
            end
            SK_VTG, SK_VBW: begin
                next_qVel = next_qVel | portHot;
            end
            SK_HDT, SK_THS: begin
                next_qHdg = next_qHdg | portHot;
            end
            SK_ROT: begin
                next_qRot = next_qRot | portHot;
            end
            default: begin
                next_qDatum = qDatum;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            qDatum <= '0;
            qRmc <= '0;
            qFix <= '0;
            qCogRmc <= '0;
            qVel <= '0;
            qHdg <= '0;
            qRot <= '0;
        end else begin
            qDatum <= next_qDatum;
            qRmc <= next_qRmc;
            qFix <= next_qFix;
            qCogRmc <= next_qCogRmc;
            qVel <= next_qVel;
            qHdg <= next_qHdg;
            qRot <= next_qRot;
        end
    end

    // ******
    // ranking pickers
    // ******
    ssps_prio_pick pickRmc (
        .req(qDatum & qRmc),
        .found(pickRmcFound),
        .port(pickRmcPort)
    );
    ssps_prio_pick pickFix (
        .req(qDatum & qFix),
        .found(pickFixFound),
        .port(pickFixPort)
    );
    ssps_prio_pick pickCog (
        .req(qVel | (qCogRmc & qDatum)),
        .found(pickCogFound),
        .port(pickCogPort)
    );
    ssps_prio_pick pickHdg (
        .req(qHdg),
        .found(pickHdgFound),
        .port(pickHdgPort)
    );
    ssps_prio_pick pickRot (
        .req(qRot),
        .found(pickRotFound),
        .port(pickRotPort)
    );

    // ******
    // source selection
    // ******
    // the highest qualifying port wins, with RMC ports ahead of GGA/GNS/GLL ports for position, so a better port takes over
    always_comb begin
        next_sources.pos.avail = pickRmcFound || pickFixFound;
        next_sources.pos.port = pickRmcFound ? pickRmcPort : pickFixPort;
        next_sources.cog.avail = pickCogFound;
        next_sources.cog.port = pickCogPort;
        next_sources.hdg.avail = pickHdgFound;
        next_sources.hdg.port = pickHdgPort;
        next_sources.rot.avail = pickRotFound;
        next_sources.rot.port = pickRotPort;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sources <= '0;
        end else begin
            sources <= next_sources;
        end
    end

    // ******
    // silence timers
    // ******
    // updates that count only from the selected port
    always_comb begin
        updPos = sentenceIn.valid && isPosData && sentenceIn.port == sources.pos.port;
        updCog = sentenceIn.valid && sentenceIn.port == sources.cog.port
            && (isVelKind || (sentenceIn.kind == SK_RMC && qDatum[sentenceIn.port]));
        updHdg = sentenceIn.valid && isHdgKind && sentenceIn.port == sources.hdg.port;
        updRot = sentenceIn.valid && sentenceIn.kind == SK_ROT
            && sentenceIn.port == sources.rot.port;
    end

    // a change of source starts a fresh silence window
    ssps_silence_timer #(.LIMIT(SILENCE_CYCLES)) timerPos (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .run(sources.pos.avail),
        .restart(updPos || next_sources.pos != sources.pos),
        .expire(expPos)
    );
    ssps_silence_timer #(.LIMIT(SILENCE_CYCLES)) timerCog (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .run(sources.cog.avail),
        .restart(updCog || next_sources.cog != sources.cog),
        .expire(expCog)
    );
    ssps_silence_timer #(.LIMIT(SILENCE_CYCLES)) timerHdg (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .run(sources.hdg.avail),
        .restart(updHdg || next_sources.hdg != sources.hdg),
        .expire(expHdg)
    );
    ssps_silence_timer #(.LIMIT(SILENCE_CYCLES)) timerRot (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .run(sources.rot.avail),
        .restart(updRot || next_sources.rot != sources.rot),
        .expire(expRot)
    );

    // ******
    // sentence filter and fix quality
    // ******
    always_comb begin
        next_sentenceOut = sentenceIn;
        if (isPosKind) begin
            // position group only from the position source
            next_sentenceOut.valid = sentenceIn.valid && sources.pos.avail
                && sentenceIn.port == sources.pos.port;
        end else if (isVelKind) begin
            next_sentenceOut.valid = sentenceIn.valid && sources.cog.avail
                && sentenceIn.port == sources.cog.port;
        end else if (isHdgKind) begin
            next_sentenceOut.valid = sentenceIn.valid && sources.hdg.avail
                && sentenceIn.port == sources.hdg.port;
        end else if (sentenceIn.kind == SK_ROT) begin
            next_sentenceOut.valid = sentenceIn.valid && sources.rot.avail
                && sentenceIn.port == sources.rot.port;
        end
        // compatibility mode folds fix kind into none or gnss
        if (compat[sentenceIn.port]) begin
            next_sentenceOut.fixQ = (sentenceIn.fixQ == `SSPS_FIX_NONE) ?
                `SSPS_FIX_NONE : `SSPS_FIX_GNSS;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sentenceOut <= '0;
        end else begin
            sentenceOut <= next_sentenceOut;
        end
    end

    // ******
    // static data answer
    // ******
    always_comb begin
        next_staticB.valid = interrogate15;
        next_staticB.serial = serial;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            staticB <= '0;
        end else begin
            staticB <= next_staticB;
        end
    end

    // ******
    // apb register slave
    // ******
    // one wait state: pready rises on the second access cycle
    always_comb begin
        busAccess = psel && penable && !pready;
        mapped = paddr inside {`SSPS_OFF_COMPAT, `SSPS_OFF_SERIAL, `SSPS_OFF_SOURCE,
            `SSPS_OFF_QUAL};
        next_pready = busAccess;
        next_pslverr = busAccess && !mapped;
        next_prdata = '0;
        next_compat = compat;
        next_serial = serial;
        if (busAccess && !pwrite) begin
            unique case (paddr)
                `SSPS_OFF_COMPAT: begin
                    next_prdata = 32'(compat);
                end
                `SSPS_OFF_SERIAL: begin
                    next_prdata = 32'(serial);
                end
                `SSPS_OFF_SOURCE: begin
                    next_prdata = 32'(sources);
                end
                `SSPS_OFF_QUAL: begin
                    next_prdata = {8'h00, qRot, qHdg, qVel, qDatum};
                end
                default: begin
                    next_prdata = '0;
                end
            endcase
        end
        // writes land at the edge that samples pready high
        if (psel && penable && pready && pwrite) begin
            if (paddr == `SSPS_OFF_COMPAT) begin
                next_compat = pwdata[`SSPS_NPORTS-1:0];
            end else if (paddr == `SSPS_OFF_SERIAL
                && pwdata[19:14] <= `SSPS_WEEK_MAX) begin
                // week, years since 2014, count, most significant first
                next_serial = pwdata[`SSPS_SERIAL_W-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
            compat <= `SSPS_COMPAT_RST;
            serial <= `SSPS_SERIAL_RST;
        end else begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
            compat <= next_compat;
            serial <= next_serial;
        end
    end
endmodule
`default_nettype wire

// ### tb/ssps_monitor.sv
// concurrent checks on the selector's ports
`timescale 1ns/10ps
`default_nettype none
`include "ssps_params.svh"
module ssps_monitor #(
    parameter logic [`SSPS_TIMER_W-1:0] SILENCE_CYCLES = 32'h00000032
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire ssps_pkg::ssps_sentence_t sentenceIn,
    input wire logic interrogate15,
    input wire ssps_pkg::ssps_sentence_t sentenceOut,
    input wire ssps_pkg::ssps_sources_t sources,
    input wire ssps_pkg::ssps_static_t staticB
);
    import ssps_pkg::*;
    // ******
    // helpers
    // ******
    ssps_sel_t lastPos; // position source one cycle back
    logic [31:0] quiet; // cycles since a position update
    logic [31:0] next_quiet;
    // position group kinds
    function automatic logic posk(input ssps_kind_t k);
        return k inside {SK_RMC, SK_GGA, SK_GNS, SK_GLL, SK_GBS, SK_GRS, SK_GSA, SK_GSV, SK_GFA};
    endfunction
    // port is not the chosen source
    function automatic logic away(input ssps_sel_t s, input ssps_port_t p);
        return !s.avail || s.port != p;
    endfunction
    // silence count restarts on a new source or an update from it
    always_comb begin
        next_quiet = quiet + 32'h1;
        if (sources.pos != lastPos || (sentenceIn.valid && sentenceIn.port == sources.pos.port
            && sentenceIn.kind inside {SK_RMC, SK_GGA, SK_GNS, SK_GLL})) begin
            next_quiet = 32'h0;
        end
    end
    // registers of the helper count
    always_ff @(posedge ref_clk) begin
        lastPos <= sys_rst ? '0 : sources.pos;
        quiet <= sys_rst ? 32'h0 : next_quiet;
    end
    // ******
    // properties
    // ******
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_ask;
        interrogate15;
    endsequence
    sequence s_ans;
        staticB.valid;
    endsequence
    property p_pos_drop;
        sentenceIn.valid && posk(sentenceIn.kind) && away(sources.pos, sentenceIn.port)
            |=> !sentenceOut.valid;
    endproperty
    property p_cog_drop;
        sentenceIn.valid && sentenceIn.kind inside {SK_VTG, SK_VBW}
            && away(sources.cog, sentenceIn.port) |=> !sentenceOut.valid;
    endproperty
    property p_hdg_drop;
        sentenceIn.valid && sentenceIn.kind inside {SK_HDT, SK_THS}
            && away(sources.hdg, sentenceIn.port) |=> !sentenceOut.valid;
    endproperty
    property p_rot_drop;
        sentenceIn.valid && sentenceIn.kind == SK_ROT && away(sources.rot, sentenceIn.port)
            |=> !sentenceOut.valid;
    endproperty
    property p_dtm_pass;
        sentenceIn.valid && sentenceIn.kind == SK_DTM
            |=> sentenceOut.valid && sentenceOut.port == $past(sentenceIn.port);
    endproperty
    property p_pos_quiet;
        sources.pos.avail |-> quiet <= SILENCE_CYCLES + 32'h4;
    endproperty
    property p_serial_ans;
        s_ask |=> s_ans;
    endproperty
    property p_serial_week;
        staticB.valid |-> staticB.serial[19:14] <= `SSPS_WEEK_MAX;
    endproperty
    a_pos_drop: assert property (p_pos_drop)
        else $error("position from unselected port");
    a_cog_drop: assert property (p_cog_drop)
        else $error("course from unselected port");
    a_hdg_drop: assert property (p_hdg_drop)
        else $error("heading from unselected port");
    a_rot_drop: assert property (p_rot_drop)
        else $error("turn from unselected port");
    a_dtm_pass: assert property (p_dtm_pass)
        else $error("datum sentence was dropped");
    a_pos_quiet: assert property (p_pos_quiet)
        else $error("silent position source kept");
    a_serial_ans: assert property (p_serial_ans)
        else $error("no static answer");
    a_serial_week: assert property (p_serial_week)
        else $error("week field above its range");
endmodule
bind ssps_top ssps_monitor #(.SILENCE_CYCLES(SILENCE_CYCLES)) i_ssps_monitor (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .sentenceIn(sentenceIn),
    .interrogate15(interrogate15),
    .sentenceOut(sentenceOut),
    .sources(sources),
    .staticB(staticB)
);
`default_nettype wire

// ### tb/ssps_sensor_model.sv
// behavioural model of the sensors feeding parsed sentences
`timescale 1ns/10ps
`default_nettype none
`include "ssps_params.svh"
module ssps_sensor_model (
    input wire logic ref_clk,
    output var ssps_pkg::ssps_sentence_t sentence
);
    import ssps_pkg::*;
    ssps_sentence_t req; // queued sentence
    logic pend = 1'b0; // a sentence waits for the next edge
    logic [12:0] junk = 13'h0a5a; // idle fields, flipped each cycle
    initial sentence = '0;
    // one sentence per cycle; fields churn while idle
    always @(posedge ref_clk) begin
        junk <= ~junk;
        if (pend) begin
            sentence <= req;
            pend <= 1'b0;
        end else begin
            sentence <= {1'b0, junk};
        end
    end
    // present one sentence, return after the edge that takes it
    task automatic send(input ssps_port_t p, input ssps_kind_t k, input logic d,
        input logic [3:0] f);
        @(posedge ref_clk);
        req <= '{1'b1, p, k, d, f};
        pend <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// ### tb/ssps_top_tb_top.sv
// self-checking bench of the sensor source priority selector
`timescale 1ns/10ps
`default_nettype none
`include "ssps_params.svh"
module ssps_top_tb_top;
    import ssps_pkg::*;
    // ******
    // signals
    // ******
    localparam logic [31:0] SIL = 32'h000000c8; // short silence for simulation
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic interrogate15 = 1'b0;
    ssps_sentence_t sentenceIn;
    ssps_sentence_t sentenceOut;
    ssps_sources_t sources;
    ssps_static_t staticB;
    logic [31:0] rd; // last read data
    logic er; // last error flag
    int err_total = 0;
    int n_tests = 0;
    int cycles = 0;
    // ******
    // instances and clock
    // ******
    ssps_top #(.SILENCE_CYCLES(SIL)) i_ssps_top (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sentenceIn(sentenceIn),
        .interrogate15(interrogate15), .sentenceOut(sentenceOut), .sources(sources),
        .staticB(staticB));
    ssps_sensor_model i_ssps_sensor_model (.ref_clk(ref_clk), .sentence(sentenceIn));
    initial forever #5 ref_clk = ~ref_clk;
    // hang guard
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total = err_total + 1;
            tally_and_finish();
        end
    end
    // ******
    // tasks
    // ******
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one sentence, then whether it passed
    task automatic snd(input ssps_port_t p, input ssps_kind_t k, input logic d,
        input logic [3:0] f, input logic ev);
        i_ssps_sensor_model.send(p, k, d, f);
        #1;
        chk("sentenceOut.valid", {31'h0, ev}, {31'h0, sentenceOut.valid});
    endtask
    // sources two cycles after the last sentence
    task automatic src(input logic [15:0] e);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("sources", {16'h0, e}, {16'h0, sources});
    endtask
    function automatic logic [3:0] sel(input ssps_port_t p);
        return {1'b1, p};
    endfunction
    // ******
    // main sequence
    // ******
    initial begin
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0);
            chk("reset value", 32'h0, rd);
        end
        apb(1'b1, 12'h010, 32'hffffffff);
        chk("pslverr", 32'h1, {31'h0, er});
        snd(PORT_SENSOR3, SK_DTM, 1'b1, 4'h2, 1'b1);
        snd(PORT_SENSOR3, SK_RMC, 1'b0, 4'h2, 1'b0);
        src({sel(PORT_SENSOR3), sel(PORT_SENSOR3), 8'h0});
        snd(PORT_SENSOR2, SK_DTM, 1'b1, 4'h3, 1'b1);
        snd(PORT_SENSOR2, SK_GGA, 1'b0, 4'h3, 1'b0);
        src({sel(PORT_SENSOR3), sel(PORT_SENSOR3), 8'h0});
        snd(PORT_SENSOR2, SK_RMC, 1'b0, 4'h3, 1'b0);
        src({sel(PORT_SENSOR2), sel(PORT_SENSOR2), 8'h0});
        snd(PORT_PILOT, SK_HDT, 1'b0, 4'h0, 1'b0);
        src({sel(PORT_SENSOR2), sel(PORT_SENSOR2), sel(PORT_PILOT), 4'h0});
        snd(PORT_SENSOR1, SK_THS, 1'b0, 4'h0, 1'b0);
        snd(PORT_SENSOR1, SK_THS, 1'b0, 4'h0, 1'b1);
        snd(PORT_LONG_RANGE, SK_ROT, 1'b0, 4'h0, 1'b0);
        snd(PORT_EXT_DISPLAY, SK_VTG, 1'b0, 4'h0, 1'b0);
        snd(PORT_PILOT, SK_HDT, 1'b0, 4'h0, 1'b0);
        snd(PORT_LONG_RANGE, SK_ROT, 1'b0, 4'h0, 1'b1);
        apb(1'b0, `SSPS_OFF_SOURCE, 32'h0);
        chk("source register", {16'h0, sel(PORT_SENSOR2), sel(PORT_SENSOR2),
            sel(PORT_SENSOR1), sel(PORT_LONG_RANGE)}, rd);
        apb(1'b1, `SSPS_OFF_COMPAT, 32'h00000002);
        snd(PORT_SENSOR2, SK_GGA, 1'b0, 4'h4, 1'b1);
        chk("folded fix", 32'h1, {28'h0, sentenceOut.fixQ});
        snd(PORT_SENSOR3, SK_DTM, 1'b1, 4'h4, 1'b1);
        chk("plain fix", 32'h4, {28'h0, sentenceOut.fixQ});
        apb(1'b1, `SSPS_OFF_SERIAL,
            {12'h0, `SSPS_WEEK_MAX, `SSPS_YEAR_MAX, `SSPS_COUNT_MAX});
        @(posedge ref_clk);
        interrogate15 <= 1'b1;
        @(posedge ref_clk);
        interrogate15 <= 1'b0;
        #1;
        chk("static answer", {11'h0, 1'b1, 20'hd3fff}, {11'h0, staticB});
        apb(1'b1, `SSPS_OFF_SERIAL, {12'h0, 6'h35, 3'h0, 11'h000});
        apb(1'b0, `SSPS_OFF_SERIAL, 32'h0);
        chk("serial kept", 32'h000d3fff, rd);
        repeat (6) begin
            repeat (40) @(posedge ref_clk);
            snd(PORT_LONG_RANGE, SK_ROT, 1'b0, 4'h0, 1'b1);
        end
        src({sel(PORT_SENSOR3), sel(PORT_SENSOR3), sel(PORT_PILOT),
            sel(PORT_LONG_RANGE)});
        repeat (450) @(posedge ref_clk);
        src(16'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
